/* src/dc_corr_cfg.svh */
// Purpose: Constants for the DC offset correction filter
// Assumes: Included by bare name wherever a constant is needed
// Notes:   Register indices; byte address is four times the index
`ifndef DC_CORR_CFG_SVH
`define DC_CORR_CFG_SVH

// Register map
`define DC_CTRL_IDX      8'h3D
`define DC_STAT_IDX      8'h3E
`define DC_CTRL_RESET    8'h00
`define REG_IDX_LSB      2
`define REG_IDX_MSB      9

// Control fields
`define CTRL_ON_BIT      0
`define CTRL_SEL_LSB     1
`define CTRL_SEL_MSB     2

// Status fields
`define STAT_ON_BIT      0
`define STAT_LVL_LSB     4
`define STAT_LVL_MSB     7

// Data path
`define SAMPLE_W         14
`define FRAC_W           24
`define ACC_W            38
`define FIFO_DEPTH       8
`define FIFO_AW          3

// Time constants in ns at 250 MSPS; shift k gives tau = 2**k / Fs
`define TC0_NS           17000
`define TC1_NS           130000
`define TC2_NS           1100000
`define TC3_NS           8400000
`define TC0_SHIFT        6'd12
`define TC1_SHIFT        6'd15
`define TC2_SHIFT        6'd18
`define TC3_SHIFT        6'd21

`endif

/* src/dc_corr_pkg.sv */
// Purpose: Types shared by the DC offset correction filter
// Assumes: Constants come from dc_corr_cfg.svh
// Notes:   Packed carriers for samples and the control register
`include "dc_corr_cfg.svh"

package dc_corr_pkg;

  typedef logic signed [`SAMPLE_W-1:0] sample_t;

  typedef struct packed {
    sample_t data;
  } sample_s;

  typedef struct packed {
    logic [4:0] spare;
    logic [1:0] time_sel;
    logic       on;
  } dc_ctrl_s;

  typedef enum logic [1:0] {
    TC_SHORT  = 2'b00,
    TC_MID    = 2'b01,
    TC_LONG   = 2'b10,
    TC_LONGER = 2'b11
  } dc_filter_time_select_e;

endpackage

/* src/sample_fifo.sv */
// Purpose: Small FIFO with valid/ready on both sides
// Assumes: One clock, asynchronous active-low reset
// Notes:   Read data leave through a register; level counts stored words
`timescale 1ns/10ps

module sample_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output      logic             in_ready,
  // Drain side
  output      logic [WIDTH-1:0] out_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  // Fill level of the memory
  output      logic [AW:0]      level
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;

  wire push = in_valid && in_ready;
  wire load = (level != '0) && (!out_valid || out_ready);

  assign in_ready = (level < (AW+1)'(DEPTH));

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      level     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (load)
      begin
        rd_ptr   <= rd_ptr + 1'b1;
        out_data <= mem[rd_ptr];
      end
      if (load)
        out_valid <= 1'b1;
      else if (out_ready)
        out_valid <= 1'b0;
      level <= level + (AW+1)'(push) - (AW+1)'(load);
    end
  end

endmodule // sample_fifo

/* src/dc_offset_correction_filter.sv */
// Purpose: DC-blocking high-pass stage in the converter sample stream
// Assumes: Samples signed, synchronous to CORE_CLK; Avalon-MM slave port
// Notes:   One cycle of filter latency, then an 8-word output FIFO
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/10ps
`include "dc_corr_cfg.svh"

module dc_offset_correction_filter (
  // Clock and reset
  input  wire logic                 CORE_CLK,
  input  wire logic                 NRST,
  // Avalon-MM slave, byte addressed
  input  wire logic [9:0]           AVS_ADDRESS,
  input  wire logic                 AVS_READ,
  input  wire logic                 AVS_WRITE,
  input  wire logic [31:0]          AVS_WRITEDATA,
  input  wire logic [3:0]           AVS_BYTEENABLE,
  output      logic [31:0]          AVS_READDATA,
  output      logic                 AVS_WAITREQUEST,
  // Sample stream in from the converter core
  input  wire dc_corr_pkg::sample_s SAMPLE_IN,
  input  wire logic                 SAMPLE_IN_VALID,
  output      logic                 SAMPLE_IN_READY,
  // Corrected stream out to the serializer
  output      dc_corr_pkg::sample_s SAMPLE_OUT,
  output      logic                 SAMPLE_OUT_VALID,
  input  wire logic                 SAMPLE_OUT_READY
);

  import dc_corr_pkg::*;

  // Shift for each time-select code; tau = 2**shift sample periods
  function automatic logic [5:0] shift_for(input dc_filter_time_select_e sel);
    logic [5:0] k;
    k = `TC0_SHIFT;
    case (sel)
      TC_SHORT:  k = `TC0_SHIFT;
      TC_MID:    k = `TC1_SHIFT;
      TC_LONG:   k = `TC2_SHIFT;
      TC_LONGER: k = `TC3_SHIFT;
      default:   k = `TC0_SHIFT;
    endcase
    return k;
  endfunction

  // Clamp a widened difference back to the sample range
  function automatic sample_t clamp(input logic signed [`SAMPLE_W:0] v);
    logic signed [`SAMPLE_W:0] hi;
    logic signed [`SAMPLE_W:0] lo;
    hi = (`SAMPLE_W+1)'({1'b0, {(`SAMPLE_W-1){1'b1}}});
    // Negative limit is the complement of the positive one
    lo = ~hi;
    if (v > hi)
      return hi[`SAMPLE_W-1:0];
    else if (v < lo)
      return lo[`SAMPLE_W-1:0];
    else
      return v[`SAMPLE_W-1:0];
  endfunction

  dc_ctrl_s                   dc_correction_control;
  logic                       ack;
  logic                       bus_wait;
  logic [31:0]                rd_data;
  logic signed [`ACC_W-1:0]   dc_acc;
  sample_t                    stage_data;
  logic                       stage_valid;
  logic                       in_ready;
  logic                       fifo_in_ready;
  logic [`FIFO_AW:0]          fifo_level;
  logic [`SAMPLE_W-1:0]       fifo_out_data;

  // Register decode
  wire [7:0] reg_idx  = AVS_ADDRESS[`REG_IDX_MSB:`REG_IDX_LSB];
  wire       hit_ctrl = (reg_idx == `DC_CTRL_IDX);
  wire       hit_stat = (reg_idx == `DC_STAT_IDX);
  wire       req      = AVS_READ || AVS_WRITE;
  wire       wr_ctrl  = AVS_WRITE && ack && hit_ctrl && AVS_BYTEENABLE[0];
  // Answer on the edge after the request is first seen
  wire       next_ack = req && !ack;

  // Control bits steering the filter
  wire                    dc_correction_on      = dc_correction_control.on;
  wire dc_filter_time_select_e dc_filter_time_select =
    dc_filter_time_select_e'(dc_correction_control.time_sel);
  wire [5:0]              shift = shift_for(dc_filter_time_select);

  // Status word: correction state and FIFO fill
  wire [7:0] status_byte = {fifo_level, 3'b000, dc_correction_on};

  // Unmapped reads answer zero; bits above the byte read zero
  wire [31:0] next_rd_data = hit_ctrl ? {24'h00_0000, dc_correction_control} :
                             hit_stat ? {24'h00_0000, status_byte} :
                                        32'h0000_0000;

  // Filter arithmetic: estimate the DC level, subtract it
  wire take = SAMPLE_IN_VALID && in_ready;
  wire signed [`ACC_W:0] x_wide = (`ACC_W+1)'(signed'(SAMPLE_IN.data)) <<< `FRAC_W;
  wire signed [`ACC_W:0] err    = x_wide - (`ACC_W+1)'(dc_acc);
  wire signed [`ACC_W:0] step   = err >>> shift;
  wire signed [`ACC_W-1:0] next_dc_acc = dc_acc + step[`ACC_W-1:0];
  wire signed [`SAMPLE_W-1:0] dc_level = dc_acc[`ACC_W-1:`FRAC_W];
  wire signed [`SAMPLE_W:0] corrected =
    (`SAMPLE_W+1)'(SAMPLE_IN.data) - (`SAMPLE_W+1)'(dc_level);
  // Same single register stage either way, so toggling keeps alignment
  wire sample_t next_stage_data = dc_correction_on ? clamp(corrected)
                                                   : SAMPLE_IN.data;

  // Accept only when the FIFO keeps room for the sample in flight
  wire push = stage_valid && fifo_in_ready;
  wire [`FIFO_AW+1:0] committed = (`FIFO_AW+2)'(fifo_level) + (`FIFO_AW+2)'(stage_valid)
                                  + (`FIFO_AW+2)'(take);
  wire next_in_ready = fifo_in_ready &&
                       (committed <= (`FIFO_AW+2)'(`FIFO_DEPTH - 1));

  assign SAMPLE_IN_READY = in_ready;
  assign SAMPLE_OUT.data = fifo_out_data;
  assign AVS_READDATA    = rd_data;
  assign AVS_WAITREQUEST = bus_wait;

  // Bus handshake: one wait state, then a single-cycle answer
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      ack <= 1'b0;
    else
      ack <= next_ack;
  end

  // Waitrequest has its own flop, so no logic sits behind the port
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      bus_wait <= 1'b1;
    else
      bus_wait <= !next_ack;
  end

  // Read data refreshed every cycle from the address on the bus
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      rd_data <= 32'h0000_0000;
    else
      rd_data <= next_rd_data;
  end

  // Host keeps bits 7:3 at zero; stored as written
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      dc_correction_control <= dc_ctrl_s'(`DC_CTRL_RESET);
    else if (wr_ctrl)
      dc_correction_control <= dc_ctrl_s'(AVS_WRITEDATA[7:0]);
  end

  // Estimator held at zero while off, so enabling starts clean
  // Floor shift keeps the estimate under one LSB low
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      dc_acc <= '0;
    else if (!dc_correction_on)
      dc_acc <= '0;
    else if (take)
      dc_acc <= next_dc_acc;
  end

  // Input ready from a flop, so the source sees no combinational path
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      in_ready <= 1'b0;
    else
      in_ready <= next_in_ready;
  end

  // One-sample stage; holds until the FIFO accepts it
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      stage_data <= '0;
    else if (take)
      stage_data <= next_stage_data;
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      stage_valid <= 1'b0;
    else if (take)
      stage_valid <= 1'b1;
    else if (push)
      stage_valid <= 1'b0;
  end

  sample_fifo #(
    .WIDTH (`SAMPLE_W),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .clk       (CORE_CLK),
    .rst_n     (NRST),
    .in_data   (stage_data),
    .in_valid  (stage_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (SAMPLE_OUT_VALID),
    .out_ready (SAMPLE_OUT_READY),
    .level     (fifo_level)
  );

endmodule // dc_offset_correction_filter

/* dv/dc_corr_asserts.sv */
// Purpose: Port checks for the DC correction filter
// Assumes: Sees top-level ports only
// Notes:   Latency window allows for the registered FIFO output
`timescale 1ns/10ps
module dc_corr_asserts (
  // Clock and reset
  input wire logic                 CORE_CLK,
  input wire logic                 NRST,
  // Register bus
  input wire logic                 AVS_READ,
  input wire logic [31:0]          AVS_READDATA,
  input wire logic                 AVS_WAITREQUEST,
  // Stream
  input wire logic                 SAMPLE_IN_VALID,
  input wire logic                 SAMPLE_IN_READY,
  input wire dc_corr_pkg::sample_s SAMPLE_OUT,
  input wire logic                 SAMPLE_OUT_VALID,
  input wire logic                 SAMPLE_OUT_READY
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  sequence bus_ack;
    ##[1:2] !AVS_WAITREQUEST;
  endsequence
  sequence took_before;
    $past(SAMPLE_IN_VALID && SAMPLE_IN_READY, 3) || $past(SAMPLE_IN_VALID && SAMPLE_IN_READY, 4);
  endsequence
  bus_answer_a: assert property ($rose(AVS_READ) |-> bus_ack)
    else $error("register read not answered");
  read_upper_a: assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  out_latency_a: assert property ($rose(SAMPLE_OUT_VALID) |-> took_before)
    else $error("output latency differs");
  out_hold_a: assert property (SAMPLE_OUT_VALID && !SAMPLE_OUT_READY |=>
    SAMPLE_OUT_VALID && $stable(SAMPLE_OUT)) else $error("output dropped while stalled");
  reset_state_a: assert property ($rose(NRST) |-> !SAMPLE_OUT_VALID && AVS_WAITREQUEST)
    else $error("bad state after reset");
endmodule // dc_corr_asserts

bind dc_offset_correction_filter dc_corr_asserts u_chk (.CORE_CLK, .NRST, .AVS_READ,
  .AVS_READDATA, .AVS_WAITREQUEST, .SAMPLE_IN_VALID, .SAMPLE_IN_READY, .SAMPLE_OUT,
  .SAMPLE_OUT_VALID, .SAMPLE_OUT_READY);

/* dv/sample_source.sv */
// Purpose: Converter core model feeding the sample stream
// Assumes: Holds a sample until it is taken
// Notes:   Idle data toggle so stale values never look valid
`timescale 1ns/10ps
module sample_source
  import dc_corr_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    rst_n,
  input  wire logic    go,
  input  wire sample_t value,
  input  wire logic    ready,
  output sample_s      data,
  output logic         valid
);
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      valid <= 1'b0;
      data  <= '0;
    end
    else if (!valid || ready)
    begin
      valid     <= go;
      data.data <= go ? value : ~data.data;
    end
endmodule // sample_source

/* dv/dc_offset_correction_filter_tb.sv */
// Purpose: Self-checking bench for the DC correction filter
// Assumes: Constant input level, so the output shows the DC decay
// Notes:   Decay compared with an exponential, tolerance 20 LSB
`timescale 1ns/10ps
module dc_offset_correction_filter_tb;
  import dc_corr_pkg::*;
  logic        clk, nrst, rd, wr, go, iv, ir, ov, ordy, wq, pass;
  logic [9:0]  addr;
  logic [31:0] wdat, rdat, q;
  sample_s     sin, sout;
  sample_t     val, last;
  int          err_count, total_checks, cycles, nout;
  real         e;

  dc_offset_correction_filter uut (.CORE_CLK(clk), .NRST(nrst), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'h1),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq), .SAMPLE_IN(sin), .SAMPLE_IN_VALID(iv),
    .SAMPLE_IN_READY(ir), .SAMPLE_OUT(sout), .SAMPLE_OUT_VALID(ov), .SAMPLE_OUT_READY(ordy));
  sample_source src (.clk(clk), .rst_n(nrst), .go(go), .value(val), .ready(ir),
    .data(sin), .valid(iv));

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
      err_count++;
    end
  endtask

  task automatic end_sim;
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr   <= w;
    rd   <= !w;
    wdat <= {24'h00_0000, d};
    do @(posedge clk); while (wq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic run(input int n);
    nout = 0;
    while (nout < n) @(posedge clk);
  endtask

  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      err_count++;
      end_sim();
    end
    if (ov && ordy)
    begin
      nout++;
      last = sout.data;
      if (pass) chk(32'(sout.data), 32'(val));
    end
  end

  initial
  begin
    {nrst, rd, wr, go, ordy, pass, addr, wdat} = '0;
    val = 14'sh03E8;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    bus(0, 10'h0F4, 8'h00); chk(q, 32'h0000_0000);
    bus(0, 10'h3FC, 8'h00); chk(q, 32'h0000_0000);
    go <= 1'b1;
    ordy <= 1'b1;
    pass = 1;
    run(3000);
    ordy <= 1'b0;
    while (ir !== 1'b0) @(posedge clk);
    bus(0, 10'h0F8, 8'h00); chk(q, 32'h0000_0080);
    ordy <= 1'b1;
    run(50);
    pass = 0;
    for (int c = 0; c < 4; c++)
    begin
      bus(1, 10'h0F4, 8'h00);
      bus(1, 10'h0F4, 8'(2 * c + 1));
      bus(0, 10'h0F4, 8'h00); chk(q, 32'(2 * c + 1));
      run(12000);
      e = 1000.0 * $exp(-12000.0 / (2.0 ** (12 + 3 * c)));
      chk(32'(($itor(last) - e) < 20.0 && ($itor(last) - e) > -20.0), 32'h1);
    end
    // Full-scale negative step: output must saturate, not wrap
    val <= 14'sh2000;
    run(20);
    chk(32'(last), 32'hFFFF_E000);
    // Reset in mid-run clears the control register
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    bus(0, 10'h0F4, 8'h00); chk(q, 32'h0000_0000);
    pass = 1;
    run(20);
    end_sim();
  end
endmodule // dc_offset_correction_filter_tb
